// ==== verilog/usart_irq_regs.v ====
// register map and interrupt aggregation of the serial transceiver
// What this block does
// - all enabled event sources are ORed onto one global interrupt output.
// - an event reaches the interrupt only while an enable bit that covers it is set.
// - tx empty, cts change, tx complete, idle, parity and line break interrupt.
// - received data ready interrupts when rx-not-empty enable is set.
// - receive overrun interrupts through the rx-not-empty enable.
// - noise, overrun and framing errors interrupt through the error enable.
// - the error enable only acts while dma reception is enabled.
// - tx empty resets to one, set on shift load, cleared by data write.
// - tx complete resets to one, set on finish with empty buffer, software clears.
`timescale 1ns/1ps
`include "usart_regs.vh"

module usart_irq_regs (
    // clock and reset
    input  wire                    pclk,
    input  wire                    presetn,
    // apb slave
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [7:0]              paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output wire                    pready,
    output reg                     pslverr,
    // events from the serial engine, one-cycle pulses on pclk
    input  wire                    tx_load_pulse,
    input  wire                    tx_done_pulse,
    input  wire                    cts_change_pulse,
    input  wire                    idle_pulse,
    input  wire                    line_break_pulse,
    input  wire                    rx_data_pulse,
    input  wire [`DATA_WIDTH-1:0]  rx_data,
    input  wire                    rx_parity_err,
    input  wire                    rx_framing_err,
    input  wire                    rx_noise_err,
    // transmit data toward the serial engine
    output reg  [`DATA_WIDTH-1:0]  tx_data,
    output wire                    tx_pending,
    // configuration toward the serial engine
    output reg  [`HALF_WIDTH-1:0]  baud_divider,
    output reg  [`C1_WIDTH-1:0]    control_one,
    output reg  [`C2_WIDTH-1:0]    control_two,
    output reg  [`C3_WIDTH-1:0]    control_three,
    output reg  [`HALF_WIDTH-1:0]  guard_time_prescale,
    // interrupt
    output reg                     irq
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    wire setup_phase;
    wire access_done;
    wire wr_en;
    wire rd_en;
    wire sel_status;
    wire sel_data;
    wire sel_baud;
    wire sel_c1;
    wire sel_c2;
    wire sel_c3;
    wire sel_gtp;
    wire hit;

    // zero wait states: every access completes in its first access cycle
    assign pready      = 1'b1;
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable;
    assign wr_en       = access_done & pwrite;
    assign rd_en       = access_done & ~pwrite;

    assign sel_status = (paddr == `OFS_LINE_STATUS);
    assign sel_data   = (paddr == `OFS_DATA_WINDOW);
    assign sel_baud   = (paddr == `OFS_BAUD_DIVIDER);
    assign sel_c1     = (paddr == `OFS_CONTROL_ONE);
    assign sel_c2     = (paddr == `OFS_CONTROL_TWO);
    assign sel_c3     = (paddr == `OFS_CONTROL_THREE);
    assign sel_gtp    = (paddr == `OFS_GUARD_TIME);
    assign hit        = sel_status | sel_data | sel_baud | sel_c1 | sel_c2 | sel_c3 | sel_gtp;

    ////////////////////////////////////////////////////////////////////////
    // status flags

    wire [`ST_WIDTH-1:0] status_r;
    reg  [`ST_WIDTH-1:0] status_set;
    reg  [`ST_WIDTH-1:0] status_clr;
    reg  [`ST_WIDTH-1:0] seq_snap_r;
    reg                  seq_armed_r;
    reg  [`DATA_WIDTH-1:0] rx_buf_r;
    wire                 overrun_error_flag;
    wire                 rx_accept;
    wire                 data_read;
    wire                 data_write;

    assign data_read  = rd_en & sel_data;
    assign data_write = wr_en & sel_data;
    // new byte while the previous one is unread is an overrun; old byte kept
    assign overrun_error_flag = rx_data_pulse & status_r[`ST_RX_NOT_EMPTY];
    assign rx_accept          = rx_data_pulse & ~status_r[`ST_RX_NOT_EMPTY];

    always @* begin
        status_set = {`ST_WIDTH{1'b0}};
        status_clr = {`ST_WIDTH{1'b0}};
        status_set[`ST_PARITY]       = rx_accept & rx_parity_err;
        status_set[`ST_FRAMING]      = rx_accept & rx_framing_err;
        status_set[`ST_NOISE]        = rx_accept & rx_noise_err;
        status_set[`ST_OVERRUN]      = overrun_error_flag;
        status_set[`ST_IDLE]         = idle_pulse;
        status_set[`ST_RX_NOT_EMPTY] = rx_accept;
        status_set[`ST_TX_EMPTY]     = tx_load_pulse;
        status_set[`ST_TX_COMPLETE]  = tx_done_pulse & status_r[`ST_TX_EMPTY];
        status_set[`ST_LINE_BREAK]   = line_break_pulse & control_two[`C2_LIN_MODE];
        status_set[`ST_CTS_CHANGE]   = cts_change_pulse & control_three[`C3_CTS_EN];
        // writing zero clears the write-zero bits; ones leave them alone
        if (wr_en && sel_status) begin
            status_clr = `ST_W0C_MASK & ~pwdata[`ST_WIDTH-1:0];
        end
        if (data_read) begin
            status_clr[`ST_RX_NOT_EMPTY] = 1'b1;
            if (seq_armed_r) begin
                status_clr = status_clr | seq_snap_r;
            end
        end
        status_clr[`ST_TX_EMPTY] = data_write;
    end

    sticky_flags #(
        .WIDTH     (`ST_WIDTH),
        .RESET_VAL (`ST_RESET)
    ) u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .set_in  (status_set),
        .clr_in  (status_clr),
        .flags_r (status_r)
    );

    // a status read arms the sequence clear; only flags present in its access cycle are cleared
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_armed_r <= 1'b0;
            seq_snap_r  <= {`ST_WIDTH{1'b0}};
        end else if (access_done) begin
            if (rd_en && sel_status) begin
                seq_armed_r <= 1'b1;
                seq_snap_r  <= status_r & `ST_SEQ_MASK;
            end else begin
                seq_armed_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data window and configuration registers

    assign tx_pending = ~status_r[`ST_TX_EMPTY];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_r <= `DATA_RESET;
        end else if (rx_accept) begin
            rx_buf_r <= rx_data;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data             <= `DATA_RESET;
            baud_divider        <= `HALF_RESET;
            control_one         <= `C1_RESET;
            control_two         <= `C2_RESET;
            control_three       <= `C3_RESET;
            guard_time_prescale <= `HALF_RESET;
        end else if (wr_en) begin
            if (sel_data) begin
                tx_data <= pwdata[`DATA_WIDTH-1:0];
            end else if (sel_baud) begin
                baud_divider <= pwdata[`HALF_WIDTH-1:0];
            end else if (sel_c1) begin
                control_one <= pwdata[`C1_WIDTH-1:0];
            end else if (sel_c2) begin
                control_two <= pwdata[`C2_WIDTH-1:0] & `C2_MASK;
            end else if (sel_c3) begin
                control_three <= pwdata[`C3_WIDTH-1:0];
            end else if (sel_gtp) begin
                guard_time_prescale <= pwdata[`HALF_WIDTH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup cycle so it is stable for the access

    reg [31:0] rdata_nxt;

    always @* begin
        rdata_nxt = 32'h00000000;
        if (sel_status) begin
            rdata_nxt[`ST_WIDTH-1:0] = status_r;
        end else if (sel_data) begin
            rdata_nxt[`DATA_WIDTH-1:0] = rx_buf_r;
        end else if (sel_baud) begin
            rdata_nxt[`HALF_WIDTH-1:0] = baud_divider;
        end else if (sel_c1) begin
            rdata_nxt[`C1_WIDTH-1:0] = control_one;
        end else if (sel_c2) begin
            rdata_nxt[`C2_WIDTH-1:0] = control_two;
        end else if (sel_c3) begin
            rdata_nxt[`C3_WIDTH-1:0] = control_three;
        end else if (sel_gtp) begin
            rdata_nxt[`HALF_WIDTH-1:0] = guard_time_prescale;
        end
    end

    // limitation: the status snapshot is one cycle old by the end of the access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= pwrite ? 32'h00000000 : rdata_nxt;
            pslverr <= ~hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt aggregation

    wire src_tx_empty;
    wire src_cts;
    wire src_tx_complete;
    wire src_rx;
    wire src_overrun;
    wire src_idle;
    wire src_parity;
    wire src_break;
    wire src_error;
    wire irq_nxt;

    assign src_tx_empty    = status_r[`ST_TX_EMPTY] & control_one[`C1_TX_EMPTY_IEN];
    assign src_cts         = status_r[`ST_CTS_CHANGE] & control_three[`C3_CTS_IEN];
    assign src_tx_complete = status_r[`ST_TX_COMPLETE] & control_one[`C1_TX_COMPLETE_IEN];
    assign src_rx          = status_r[`ST_RX_NOT_EMPTY] & control_one[`C1_RX_NOT_EMPTY_IEN];
    // overrun shares the rx enable
    assign src_overrun     = status_r[`ST_OVERRUN] & control_one[`C1_RX_NOT_EMPTY_IEN];
    assign src_idle        = status_r[`ST_IDLE] & control_one[`C1_IDLE_IEN];
    assign src_parity      = status_r[`ST_PARITY] & control_one[`C1_PARITY_IEN];
    assign src_break       = status_r[`ST_LINE_BREAK] & control_two[`C2_LINE_BREAK_IEN];
    // error path is meaningful only when dma drains the receiver
    assign src_error       = control_three[`C3_ERROR_IEN] & control_three[`C3_DMA_RX_EN] &
                             (status_r[`ST_NOISE] | status_r[`ST_OVERRUN] |
                              status_r[`ST_FRAMING]);

    assign irq_nxt = src_tx_empty | src_cts | src_tx_complete | src_rx | src_overrun |
                     src_idle | src_parity | src_break | src_error;

    // registered so the line is glitch free; it falls one cycle after the last cause
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_nxt;
        end
    end

endmodule // usart_irq_regs

// ==== verilog/usart_regs.vh ====
// register offsets, field positions and reset values of the serial port register map
`ifndef USART_REGS_VH
`define USART_REGS_VH

// register byte offsets
`define OFS_LINE_STATUS      8'h00
`define OFS_DATA_WINDOW      8'h04
`define OFS_BAUD_DIVIDER     8'h08
`define OFS_CONTROL_ONE      8'h0C
`define OFS_CONTROL_TWO      8'h10
`define OFS_CONTROL_THREE    8'h14
`define OFS_GUARD_TIME       8'h18

// line_status bit positions
`define ST_PARITY            0
`define ST_FRAMING           1
`define ST_NOISE             2
`define ST_OVERRUN           3
`define ST_IDLE              4
`define ST_RX_NOT_EMPTY      5
`define ST_TX_COMPLETE       6
`define ST_TX_EMPTY          7
`define ST_LINE_BREAK        8
`define ST_CTS_CHANGE        9
`define ST_WIDTH             10
`define ST_RESET             10'h0C0
// bits cleared by writing zero
`define ST_W0C_MASK          10'h360
// bits cleared by the status-read then data-read sequence
`define ST_SEQ_MASK          10'h01F

// control_one bit positions
`define C1_IDLE_IEN          4
`define C1_RX_NOT_EMPTY_IEN  5
`define C1_TX_COMPLETE_IEN   6
`define C1_TX_EMPTY_IEN      7
`define C1_PARITY_IEN        8
`define C1_WIDTH             14
`define C1_RESET             14'h0000

// control_two bit positions
`define C2_LINE_BREAK_IEN    6
`define C2_LIN_MODE          14
`define C2_WIDTH             15
`define C2_MASK              15'h7F6F
`define C2_RESET             15'h0000

// control_three bit positions
`define C3_ERROR_IEN         0
`define C3_DMA_RX_EN         6
`define C3_CTS_EN            9
`define C3_CTS_IEN           10
`define C3_WIDTH             11
`define C3_RESET             11'h000

// other widths and resets
`define DATA_WIDTH           9
`define DATA_RESET           9'h000
`define HALF_WIDTH           16
`define HALF_RESET           16'h0000

`endif

// ==== verilog/sticky_flags.v ====
// bank of sticky hardware flags where a set beats a clear in the same cycle
`timescale 1ns/1ps

module sticky_flags #(
    parameter             WIDTH     = 10,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // per-bit controls
    input  wire [WIDTH-1:0] set_in,
    input  wire [WIDTH-1:0] clr_in,
    // flag state
    output reg  [WIDTH-1:0] flags_r
);

    wire [WIDTH-1:0] flags_nxt;

    // set wins so an event landing on the clear cycle is never lost
    assign flags_nxt = set_in | (flags_r & ~clr_in);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= RESET_VAL;
        end else begin
            flags_r <= flags_nxt;
        end
    end

endmodule // sticky_flags

// ==== tb/usart_irq_chk.sv ====
// port-level assertions for the serial port register and interrupt block
`timescale 1ns/1ps
module usart_irq_chk (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // engine side
    input wire        tx_load_pulse,
    input wire [8:0]  tx_data,
    input wire        tx_pending,
    input wire [13:0] control_one,
    input wire [14:0] control_two,
    input wire [10:0] control_three,
    input wire        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_dat = psel & penable & pwrite & (paddr == 8'h04);
    wire no_en = (control_one[8:4] == 5'h00) & ~control_two[6] & ~control_three[10]
                 & ~control_three[0];
    no_wait_a: assert property (pready) else $error("pready low");
    txe_set_a: assert property (tx_load_pulse |=> !tx_pending)
        else $error("load did not empty buffer");
    txe_clr_a: assert property (wr_dat && !tx_load_pulse |=> tx_pending)
        else $error("data write left buffer empty");
    tx_data_a: assert property (wr_dat |=> {23'h000000, tx_data} == ($past(pwdata) & 32'h000001FF))
        else $error("tx data not taken");
    irq_txe_a: assert property ((!tx_pending && control_one[7]) [*2] |-> irq)
        else $error("empty buffer irq missing");
    irq_off_a: assert property (no_en |=> !irq)
        else $error("irq with no enable");
    slv_err_a: assert property (psel && !penable && paddr > 8'h18 |=> pslverr)
        else $error("unmapped access not flagged");
    wr_zero_a: assert property (psel && !penable && pwrite |=> prdata == 32'h00000000)
        else $error("read data on write");
endmodule // usart_irq_chk
bind usart_irq_regs usart_irq_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_load_pulse(tx_load_pulse), .tx_data(tx_data),
    .tx_pending(tx_pending), .control_one(control_one), .control_two(control_two),
    .control_three(control_three), .irq(irq));

// ==== tb/engine_model.sv ====
// stand-in for the serial engine: turns a command into one-cycle event pulses
`timescale 1ns/1ps
module engine_model (
    // clock and command
    input  wire       pclk,
    input  wire       go,
    input  wire [2:0] ev,
    input  wire [2:0] err,
    input  wire [8:0] dat,
    // events
    output reg        tx_load_pulse = 1'b0,
    output reg        tx_done_pulse = 1'b0,
    output reg        cts_change_pulse = 1'b0,
    output reg        idle_pulse = 1'b0,
    output reg        line_break_pulse = 1'b0,
    output reg        rx_data_pulse = 1'b0,
    output reg  [8:0] rx_data = 9'h000,
    output reg  [2:0] rx_err = 3'h0
);
    wire rx = go && ev == 3'h5;
    always @(posedge pclk) begin
        tx_load_pulse    <= go && ev == 3'h0;
        tx_done_pulse    <= go && ev == 3'h1;
        cts_change_pulse <= go && ev == 3'h2;
        idle_pulse       <= go && ev == 3'h3;
        line_break_pulse <= go && ev == 3'h4;
        rx_data_pulse    <= rx;
        // levels are only meaningful with the pulse, so they churn otherwise
        rx_data <= rx ? dat : ~rx_data;
        rx_err  <= rx ? err : ~rx_err;
    end
endmodule // engine_model

// ==== tb/testbench.sv ====
// self-checking bench for the register map and interrupt block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0, rd;
    reg [2:0] ev = 3'h0, err = 3'h0;
    reg [8:0] dat = 9'h000;
    wire [31:0] prdata;
    wire pready, pslverr, tl, td, tc, ti, tb, tr, tx_pending, irq;
    wire [8:0] rxd, tx_data;
    wire [15:0] baud, gtp;
    wire [14:0] c2;
    wire [13:0] c1;
    wire [10:0] c3;
    wire [2:0] re;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    engine_model u_eng (.pclk(pclk), .go(go), .ev(ev), .err(err), .dat(dat),
        .tx_load_pulse(tl), .tx_done_pulse(td), .cts_change_pulse(tc), .idle_pulse(ti),
        .line_break_pulse(tb), .rx_data_pulse(tr), .rx_data(rxd), .rx_err(re));
    usart_irq_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_load_pulse(tl), .tx_done_pulse(td), .cts_change_pulse(tc),
        .idle_pulse(ti), .line_break_pulse(tb), .rx_data_pulse(tr), .rx_data(rxd),
        .rx_parity_err(re[0]), .rx_framing_err(re[1]), .rx_noise_err(re[2]),
        .tx_data(tx_data), .tx_pending(tx_pending), .baud_divider(baud), .control_one(c1),
        .control_two(c2), .control_three(c3), .guard_time_prescale(gtp), .irq(irq));
    initial forever #4 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            conclude;
        end
    end
    task apb(input bit w, input [7:0] a, input [31:0] d);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task w(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task fire(input [2:0] e, input [2:0] x, input [8:0] d);
        @(posedge pclk) {go, ev, err, dat} <= {1'b1, e, x, d};
        @(posedge pclk) go <= 1'b0;
        w(3);
    endtask
    // write-zero clears bits 9,8,6,5; status then data read clears 0..4
    task clear;
        apb(1, 8'h00, 32'h0);
        apb(0, 8'h00, 32'h0);
        apb(0, 8'h04, 32'h0);
        w(2);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        `CHK({irq, tx_pending}, 2'b00)
        for (int a = 0; a <= 8'h18; a += 4) begin
            apb(0, a[7:0], 32'h0);
            `CHK(rd, (a == 0) ? 32'h000000C0 : 32'h0)
        end
        apb(0, 8'h1C, 32'h0);
        `CHK({pslverr, rd}, {1'b1, 32'h0})
    endtask
    task t_tx;
        apb(1, 8'h00, 32'h0);
        apb(1, 8'h0C, 32'h40); w(2); `CHK(irq, 1'b0)
        apb(1, 8'h0C, 32'hC0); w(2); `CHK(irq, 1'b1)
        apb(1, 8'h04, 32'h1A5); w(2); `CHK({irq, tx_pending, tx_data}, {2'b01, 9'h1A5})
        fire(1, 0, 0); `CHK(irq, 1'b0)
        fire(0, 0, 0); `CHK({irq, tx_pending}, 2'b10)
        apb(1, 8'h0C, 32'h40); w(2); `CHK(irq, 1'b0)
        fire(1, 0, 0); `CHK(irq, 1'b1)
        apb(1, 8'h00, 32'h0); w(2); `CHK(irq, 1'b0)
        apb(1, 8'h0C, 32'h0);
    endtask
    task t_events;
        reg [2:0] e, x;
        reg [7:0] a;
        reg [31:0] p, v;
        int b;
        for (int i = 0; i < 5; i++) begin
            case (i)
                0: begin e = 2; x = 0; a = 8'h14; p = 32'h200; v = 32'h600; b = 9; end
                1: begin e = 3; x = 0; a = 8'h0C; p = 32'h0; v = 32'h10; b = 4; end
                2: begin e = 4; x = 0; a = 8'h10; p = 32'h4000; v = 32'h4040; b = 8; end
                3: begin e = 5; x = 0; a = 8'h0C; p = 32'h0; v = 32'h20; b = 5; end
                default: begin e = 5; x = 1; a = 8'h0C; p = 32'h0; v = 32'h100; b = 0; end
            endcase
            apb(1, a, p);
            fire(e, x, 9'h0C3);
            `CHK(irq, 1'b0)
            apb(0, 8'h00, 32'h0); `CHK(rd[b], 1'b1)
            apb(1, a, v); w(2); `CHK(irq, 1'b1)
            apb(1, a, p); w(2); `CHK(irq, 1'b0)
            clear;
        end
        apb(1, 8'h14, 32'h0);
        apb(1, 8'h10, 32'h0);
    endtask
    task t_ovr;
        apb(1, 8'h0C, 32'h20);
        fire(5, 0, 9'h055);
        fire(5, 0, 9'h0AA);
        apb(0, 8'h04, 32'h0); `CHK(rd, 32'h055)
        w(2); `CHK(irq, 1'b1)
        clear; `CHK(irq, 1'b0)
        apb(1, 8'h0C, 32'h0);
    endtask
    task t_err;
        apb(1, 8'h14, 32'h001);
        fire(5, 3'b110, 9'h1FF); `CHK(irq, 1'b0)
        apb(1, 8'h14, 32'h041); w(2); `CHK(irq, 1'b1)
        apb(1, 8'h14, 32'h0); w(2); `CHK(irq, 1'b0)
        clear;
    endtask
    // configuration words reach their outputs; baud, guard time and control_two read back; a mid-run reset restores all
    task t_cfg;
        apb(1, 8'h08, 32'hFFFF1234);
        apb(1, 8'h18, 32'h5A5AC3A5);
        apb(1, 8'h10, 32'hFFFFFFFF);
        apb(1, 8'h0C, 32'h00002A0F);
        apb(1, 8'h14, 32'h000001BE);
        apb(1, 8'h04, 32'h000001C3);
        w(2);
        `CHK({irq, tx_pending, tx_data, baud, gtp, c2, c1, c3}, {2'b01, 9'h1C3, 16'h1234, 16'hC3A5, 15'h7F6F, 14'h2A0F, 11'h1BE})
        apb(0, 8'h08, 32'h0); `CHK(rd, 32'h00001234)
        apb(0, 8'h18, 32'h0); `CHK(rd, 32'h0000C3A5)
        apb(0, 8'h10, 32'h0); `CHK(rd, 32'h00007F6F)
        apb(0, 8'h00, 32'h0); `CHK(rd, 32'h00000000)
        @(posedge pclk) presetn <= 1'b0;
        w(2);
        `CHK({irq, tx_pending, tx_data, baud, gtp, c2, c1, c3}, 83'h0)
        @(posedge pclk) presetn <= 1'b1;
        apb(0, 8'h00, 32'h0); `CHK(rd, 32'h000000C0)
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        w(1);
        t_reset;
        t_tx;
        t_events;
        t_ovr;
        t_err;
        t_cfg;
        conclude;
    end
endmodule // testbench
